// *** common/bbsc_pkg.sv ***
`default_nettype none
package bbsc_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int CFG_W  = 4;
    localparam int LOW_HI = 7;
    localparam int HIGH_LO = 8;
    localparam int HIGH_HI = 15;
    localparam int TOP_LO = 16;
    localparam int TOP_HI = 18;
    localparam int CFG_RD_SIGN = 3;
    localparam int CFG_RD_MAG  = 2;
    localparam int CFG_WR_SIGN = 1;
    localparam int CFG_WR_MAG  = 0;
    localparam logic [1:0] CMD_WRITE          = 2'h0;
    localparam logic [1:0] CMD_READ           = 2'h1;
    localparam logic [1:0] CMD_LOAD_ADDR_LOW  = 2'h2;
    localparam logic [1:0] CMD_LOAD_ADDR_HIGH = 2'h3;
    localparam logic [3:0] CFG_RESET = 4'h0;
    localparam logic [18:0] ADDR_RESET = 19'h0;
endpackage
`default_nettype wire

// *** src/bbsc_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module bbsc_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } bbsc_sync_type;
    bbsc_sync_type st_q;
    bbsc_sync_type st_d;

    always_comb begin
        st_d = st_q;
        if (ce) begin
            st_d.s1 = async_in;
            st_d.s2 = st_q.s1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.s2;
endmodule
`default_nettype wire

// *** src/bbsc_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
// How it works
// - After reset, wait for configuration byte
// - First write strobe stores configuration, enter operating
// - Configuration accepted only with command 00
// - Operating: write, read, load low, load high
// - Codes: 00 write, 01 read, 10/11 loads
// - Only low data nibble becomes configuration
// - Stored configuration shown on indicator outputs
// - Leaving configuration clears address counter
// - Every reset forces configuration wait again
// - Configuration selects post-access address adjust
// - Bits: read sign/mag, write sign/mag
// - Address counter wraps at 19 bits
// - Load low replaces bits 7..0 only
// - Load high sets 15..8, clears 18..16
module bbsc_ctrl #(
    parameter int AW = bbsc_pkg::ADDR_W
) (
    input  wire logic                         sys_clk,
    input  wire logic                         resetn,
    input  wire logic                         ce,
    input  wire logic                         strobe_clk,
    input  wire logic                         cmd_line_hi,
    input  wire logic                         cmd_line_lo,
    input  wire logic [bbsc_pkg::DATA_W-1:0]  byte_bus_in,
    output logic      [bbsc_pkg::DATA_W-1:0]  byte_bus_out,
    output logic                              byte_bus_oe,
    output logic      [bbsc_pkg::CFG_W-1:0]   cfg_bits,
    output logic                              running,
    output logic      [AW-1:0]                mem_addr,
    output logic      [bbsc_pkg::DATA_W-1:0]  mem_wdata,
    output logic                              mem_we,
    output logic                              mem_oe_n,
    input  wire logic [bbsc_pkg::DATA_W-1:0]  mem_rdata
);
    typedef enum logic [1:0] {
        ST_CONFIG,
        ST_RUN,
        ST_ACCESS
    } bbsc_state_type;

    typedef struct packed {
        bbsc_state_type                  state;
        logic                            strobe_prev;
        logic [1:0]                      cmd;
        logic [bbsc_pkg::CFG_W-1:0]      cfg;
        logic [AW-1:0]                   addr;
        logic [bbsc_pkg::DATA_W-1:0]     dout;
        logic                            oe;
        logic                            we;
        logic                            rd_n;
        logic                            run;
    } bbsc_ctrl_type;

    bbsc_ctrl_type st_q;
    bbsc_ctrl_type st_d;

    logic [bbsc_pkg::DATA_W+2:0] sync_in;
    logic [bbsc_pkg::DATA_W+2:0] sync_out;
    logic                        strobe_s;
    logic [1:0]                  cmd_s;
    logic [bbsc_pkg::DATA_W-1:0] data_s;
    logic                        rise;

    ////////////////////////////////////////////////////////////////////////////
    // Strobe, command and data pins pass the same two flops; a strobe edge is seen in the same cycle as the data
    assign sync_in = {strobe_clk, cmd_line_hi, cmd_line_lo, byte_bus_in};

    bbsc_sync #(
        .W (bbsc_pkg::DATA_W + 3)
    ) u_sync (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .ce       (ce),
        .async_in (sync_in),
        .sync_out (sync_out)
    );

    assign strobe_s = sync_out[bbsc_pkg::DATA_W+2];
    assign cmd_s    = sync_out[bbsc_pkg::DATA_W+1:bbsc_pkg::DATA_W];
    assign data_s   = sync_out[bbsc_pkg::DATA_W-1:0];
    assign rise     = strobe_s && !st_q.strobe_prev;

    // Step of one up, one down or nothing, wrapping at the counter width
    function automatic logic [AW-1:0] adjust(input logic [AW-1:0] a, input logic sign,
                                             input logic mag);
        logic [AW-1:0] r;
        r = a;
        if (mag) begin
            r = sign ? AW'(a + AW'(1)) : AW'(a - AW'(1));
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        if (ce) begin
            st_d.strobe_prev = strobe_s;
            st_d.we = 1'b0;
            st_d.rd_n = 1'b1;
            case (st_q.state)
                ST_CONFIG: begin
                    st_d.oe = 1'b0;
                    if (rise && cmd_s == bbsc_pkg::CMD_WRITE) begin
                        st_d.cfg   = data_s[bbsc_pkg::CFG_W-1:0];
                        st_d.addr  = bbsc_pkg::ADDR_RESET;
                        st_d.run   = 1'b1;
                        st_d.state = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (rise) begin
                        st_d.cmd = cmd_s;
                        st_d.oe  = 1'b0;
                        case (cmd_s)
                            bbsc_pkg::CMD_WRITE: begin
                                st_d.dout  = data_s;
                                st_d.we    = 1'b1;
                                st_d.state = ST_ACCESS;
                            end
                            bbsc_pkg::CMD_READ: begin
                                st_d.rd_n  = 1'b0;
                                st_d.state = ST_ACCESS;
                            end
                            bbsc_pkg::CMD_LOAD_ADDR_LOW: begin
                                st_d.addr[bbsc_pkg::LOW_HI:0] = data_s;
                            end
                            default: begin
                                st_d.addr[bbsc_pkg::HIGH_HI:bbsc_pkg::HIGH_LO] = data_s;
                                st_d.addr[bbsc_pkg::TOP_HI:bbsc_pkg::TOP_LO] = '0;
                            end
                        endcase
                    end
                end
                ST_ACCESS: begin
                    // Access completes this cycle; the pointer moves only afterwards
                    if (st_q.cmd == bbsc_pkg::CMD_READ) begin
                        st_d.dout = mem_rdata;
                        st_d.oe   = 1'b1;
                        st_d.addr = adjust(st_q.addr, st_q.cfg[bbsc_pkg::CFG_RD_SIGN],
                                           st_q.cfg[bbsc_pkg::CFG_RD_MAG]);
                    end else begin
                        st_d.addr = adjust(st_q.addr, st_q.cfg[bbsc_pkg::CFG_WR_SIGN],
                                           st_q.cfg[bbsc_pkg::CFG_WR_MAG]);
                    end
                    st_d.state = ST_RUN;
                end
                default: begin
                    st_d.state = ST_CONFIG;
                    st_d.run   = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_q.state       <= ST_CONFIG;
            st_q.strobe_prev <= 1'b0;
            st_q.cmd         <= bbsc_pkg::CMD_WRITE;
            st_q.cfg         <= bbsc_pkg::CFG_RESET;
            st_q.addr        <= bbsc_pkg::ADDR_RESET;
            st_q.dout        <= '0;
            st_q.oe          <= 1'b0;
            st_q.we          <= 1'b0;
            st_q.rd_n        <= 1'b1;
            st_q.run         <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data stays driven until the next strobe so a slow host can sample it
    assign byte_bus_out = st_q.dout;
    assign byte_bus_oe  = st_q.oe;
    // Configuration holds its reset value until accepted, so no mux is needed
    assign cfg_bits     = st_q.cfg;
    assign running      = st_q.run;
    assign mem_addr     = st_q.addr;
    assign mem_wdata    = st_q.dout;
    assign mem_we       = st_q.we;
    assign mem_oe_n     = st_q.rd_n;

    ////////////////////////////////////////////////////////////////////////////
    sequence s_rise_cmd(logic [1:0] c);
        rise && cmd_s == c && ce;
    endsequence

    chk_cfg_needs_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
        st_q.state == ST_CONFIG && rise && ce && cmd_s != bbsc_pkg::CMD_WRITE
        |=> st_q.state == ST_CONFIG)
        else $error("configuration taken with nonzero command");

    chk_cfg_capture: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_q.state == ST_CONFIG) and s_rise_cmd(bbsc_pkg::CMD_WRITE)
        |=> st_q.state == ST_RUN && st_q.cfg == $past(data_s[bbsc_pkg::CFG_W-1:0]))
        else $error("configuration byte not captured");

    chk_addr_cleared: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(running) |-> mem_addr == bbsc_pkg::ADDR_RESET)
        else $error("address not cleared on entering operation");

    chk_load_low: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_q.state == ST_RUN) and s_rise_cmd(bbsc_pkg::CMD_LOAD_ADDR_LOW)
        |=> mem_addr[7:0] == $past(data_s) && mem_addr[18:8] == $past(mem_addr[18:8]))
        else $error("load low corrupted address");

    chk_load_high: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_q.state == ST_RUN) and s_rise_cmd(bbsc_pkg::CMD_LOAD_ADDR_HIGH)
        |=> mem_addr[15:8] == $past(data_s) && mem_addr[18:16] == 3'h0
            && mem_addr[7:0] == $past(mem_addr[7:0]))
        else $error("load high corrupted address");

    chk_adjust_one: assert property (@(posedge sys_clk) disable iff (!resetn)
        st_q.state == ST_ACCESS && ce |=> (mem_addr == $past(mem_addr)
            || mem_addr == AW'($past(mem_addr) + AW'(1))
            || mem_addr == AW'($past(mem_addr) - AW'(1))))
        else $error("address moved by more than one");

    chk_read_drives: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st_q.state == ST_RUN) and s_rise_cmd(bbsc_pkg::CMD_READ)
        |=> !mem_oe_n ##1 byte_bus_oe)
        else $error("read did not drive the bus");

    chk_cfg_display: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(running) |-> cfg_bits == $past(data_s[bbsc_pkg::CFG_W-1:0]))
        else $error("indicators do not show configuration");

    chk_cfg_steady: assert property (@(posedge sys_clk) disable iff (!resetn)
        running && $past(running) |-> $stable(cfg_bits))
        else $error("indicators changed while operating");
endmodule
`default_nettype wire

// *** tb/bbsc_sram_mdl.sv ***
`timescale 1ns/10ps
`default_nettype none
module bbsc_sram_mdl (
    input  wire logic        sys_clk,
    input  wire logic [18:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    input  wire logic        mem_we,
    input  wire logic        mem_oe_n,
    output logic      [7:0]  mem_rdata
);
    logic [7:0] mem [0:524287];
    bit         written [0:524287];
    logic [7:0] junk_q = 8'h5c;
    // Unselected output toggles so a stale byte never passes for read data
    always @(posedge sys_clk) begin
        junk_q <= ~junk_q;
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
            written[mem_addr] <= 1'b1;
        end
    end
    always @(mem_addr, mem_oe_n, junk_q) begin
        if (!mem_oe_n && written[mem_addr]) begin
            mem_rdata = mem[mem_addr];
        end else begin
            mem_rdata = junk_q;
        end
    end
endmodule
`default_nettype wire

// *** tb/test_byte_bus_sram_controller_startup.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_byte_bus_sram_controller_startup;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        ce = 1'b1;
    logic        strobe_clk = 1'b0;
    logic        c_hi = 1'b0;
    logic        c_lo = 1'b0;
    logic        host_en = 1'b1;
    logic [7:0]  host_d = 8'h00;
    logic [7:0]  last_q = 8'h00;
    logic [7:0]  bus_in, bus_out, wdata, rdata;
    logic        oe, run, we, oe_n;
    logic [3:0]  cfg;
    logic [18:0] addr;
    int          n_mismatch = 0;
    int          n_compared = 0;
    initial forever #4 sys_clk = ~sys_clk;
    // A released bus shows the inverse of its last level, never a held copy
    always @(posedge sys_clk) last_q <= bus_in;
    assign bus_in = host_en ? host_d : (oe ? bus_out : ~last_q);
    bbsc_ctrl i_dut (
        .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .strobe_clk(strobe_clk),
        .cmd_line_hi(c_hi), .cmd_line_lo(c_lo), .byte_bus_in(bus_in),
        .byte_bus_out(bus_out), .byte_bus_oe(oe), .cfg_bits(cfg), .running(run),
        .mem_addr(addr), .mem_wdata(wdata), .mem_we(we), .mem_oe_n(oe_n),
        .mem_rdata(rdata)
    );
    bbsc_sram_mdl i_sram (
        .sys_clk(sys_clk), .mem_addr(addr), .mem_wdata(wdata), .mem_we(we),
        .mem_oe_n(oe_n), .mem_rdata(rdata)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic op(input logic [1:0] c, input logic [7:0] d);
        @(negedge sys_clk);
        {c_hi, c_lo} = c;
        host_d = d;
        host_en = (c != bbsc_pkg::CMD_READ);
        // Ten cycles low, ten high: a 160 ns strobe period
        repeat (9) @(negedge sys_clk);
        strobe_clk = 1'b1;
        repeat (10) @(negedge sys_clk);
        strobe_clk = 1'b0;
    endtask
    task automatic rst();
        @(negedge sys_clk);
        {c_hi, c_lo, strobe_clk, host_en, host_d} = 12'h100;
        resetn = 1'b0;
        repeat (20) @(negedge sys_clk);
        resetn = 1'b1;
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst();
        chk(run, 0);
        chk(cfg, 0);
        op(bbsc_pkg::CMD_READ, 8'h0f);
        chk(run, 0);
        // Upper nibble set on purpose: the device must drop it
        op(bbsc_pkg::CMD_WRITE, 8'hfd);
        chk(cfg, 4'hd);
        chk(run, 1);
        chk(addr, 0);
        $display("test startup done");
        op(bbsc_pkg::CMD_WRITE, 8'h5a);
        chk(addr, 19'h7ffff);
        op(bbsc_pkg::CMD_WRITE, 8'ha5);
        chk(addr, 19'h7fffe);
        op(bbsc_pkg::CMD_LOAD_ADDR_LOW, 8'hff);
        chk(addr, 19'h7ffff);
        op(bbsc_pkg::CMD_READ, 8'h00);
        chk(oe, 1);
        chk(bus_out, 8'ha5);
        chk(addr, 0);
        op(bbsc_pkg::CMD_READ, 8'h00);
        chk(bus_out, 8'h5a);
        chk(addr, 1);
        op(bbsc_pkg::CMD_LOAD_ADDR_HIGH, 8'h12);
        chk(addr, 19'h01201);
        chk(oe, 0);
        op(bbsc_pkg::CMD_LOAD_ADDR_LOW, 8'h34);
        chk(addr, 19'h01234);
        // A strobe while the clock enable is low must leave no trace
        ce = 1'b0;
        op(bbsc_pkg::CMD_LOAD_ADDR_LOW, 8'h99);
        chk(addr, 19'h01234);
        ce = 1'b1;
        $display("test commands done");
        rst();
        chk(run, 0);
        chk(cfg, 0);
        op(bbsc_pkg::CMD_WRITE, 8'h0f);
        chk(cfg, 4'hf);
        op(bbsc_pkg::CMD_WRITE, 8'h77);
        chk(addr, 1);
        $display("test reconfig done");
        rst();
        op(bbsc_pkg::CMD_LOAD_ADDR_HIGH, 8'h0f);
        chk(run, 0);
        // Read steps down, write stands still
        op(bbsc_pkg::CMD_WRITE, 8'h06);
        chk(cfg, 4'h6);
        op(bbsc_pkg::CMD_WRITE, 8'h3c);
        chk(addr, 0);
        op(bbsc_pkg::CMD_READ, 8'h00);
        chk(bus_out, 8'h3c);
        chk(addr, 19'h7ffff);
        $display("test adjust modes done");
        summarize();
    end
endmodule
`default_nettype wire
